/* File: shared/loc_pkg.sv */
// Package with register map, assignment codes and timing constants for the logic output block.
package loc_pkg;
  localparam int unsigned CLOCK_HZ = 25000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] ON_DELAY_MAX_MS = 16'd60000;
  localparam logic [15:0] HOLD_MAX_MS = 16'd9999;
  localparam int unsigned NUM_OUTPUTS = 4;
  localparam int unsigned SRC_WIDTH = 5;
  localparam int unsigned NUM_SOURCES = 32;
  // Assignment codes.
  localparam logic [4:0] ASSIGN_NONE = 5'h00;
  localparam logic [4:0] ASSIGN_NO_DRIVE_FAULT = 5'h01;
  localparam logic [4:0] ASSIGN_BRAKE = 5'h02;
  localparam logic [4:0] ASSIGN_LINE_CONT = 5'h03;
  localparam logic [4:0] ASSIGN_OUTPUT_CONT = 5'h04;
  localparam logic [4:0] ASSIGN_DC_PRECHARGE = 5'h05;
  localparam logic [4:0] ASSIGN_RESET = ASSIGN_NONE;
  // Register map: four words per output, stride 0x10.
  localparam logic [11:0] OUT_STRIDE = 12'h010;
  localparam logic [3:0] REG_ASSIGN = 4'h0;
  localparam logic [3:0] REG_ON_DELAY = 4'h4;
  localparam logic [3:0] REG_HOLD = 4'h8;
  localparam logic [3:0] REG_POLARITY = 4'hC;
  localparam logic [11:0] REG_STATUS = 12'h040;
  localparam int unsigned POL_BIT = 0;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic POL_RESET = 1'b0;
endpackage

/* File: rtl/loc_channel.sv */
// One conditioning channel: on-delay, hold time and polarity for a single logic output.
`timescale 1ns/100ps
`default_nettype none
module loc_channel
  import loc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic tick,
  input wire logic info,
  input wire logic [15:0] on_delay_ms,
  input wire logic [15:0] hold_ms,
  input wire logic active_low_polarity,
  output logic pin
);
  import loc_pkg::*;

  logic state_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic nxt_state;
  logic pin_ff;
  logic pending;
  logic [15:0] limit;

  // The limit depends on the direction of the pending change.
  assign pending = (info != state_ff);
  assign limit = info ? on_delay_ms : hold_ms;

  // Count ticks while a change is pending; a return to the old state cancels it.
  always_comb begin
    nxt_state = state_ff;
    nxt_count = 16'h0000;
    if (pending) begin
      if (count_ff >= limit) begin
        nxt_state = info;
      end else if (tick) begin
        nxt_count = count_ff + 16'h0001;
        nxt_state = state_ff;
      end else begin
        nxt_count = count_ff;
      end
    end
  end

  // Registers clear on reset so the pin is defined from the start.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= 1'b0;
      count_ff <= 16'h0000;
      pin_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      pin_ff <= active_low_polarity ? !nxt_state : nxt_state;
    end
  end

  assign pin = pin_ff;
endmodule // loc_channel
`default_nettype wire

/* File: rtl/logic_output_conditioner.sv */
// Top of the logic output conditioner: APB registers, setting checks and four channels.
`timescale 1ns/100ps
`default_nettype none
module logic_output_conditioner
  import loc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] info_sources,
  input wire logic card_fitted_second,
  output logic logic_out_first,
  output logic logic_out_second,
  output logic logic_out_third,
  output logic logic_out_fourth
);
  import loc_pkg::*;

  // Assignments that pin on-delay, hold time or polarity.
  // One table of codes serves both the write checks and the forced values.
  function automatic logic fixed_on_delay(input logic [4:0] a);
    return a == ASSIGN_NO_DRIVE_FAULT || a == ASSIGN_BRAKE || a == ASSIGN_OUTPUT_CONT ||
      a == ASSIGN_DC_PRECHARGE || a == ASSIGN_LINE_CONT;
  endfunction
  function automatic logic fixed_hold(input logic [4:0] a);
    return a == ASSIGN_NO_DRIVE_FAULT || a == ASSIGN_LINE_CONT;
  endfunction
  function automatic logic fixed_polarity(input logic [4:0] a);
    return a == ASSIGN_NO_DRIVE_FAULT || a == ASSIGN_BRAKE || a == ASSIGN_DC_PRECHARGE ||
      a == ASSIGN_LINE_CONT;
  endfunction

  logic [4:0] assign_ff [NUM_OUTPUTS];
  logic [15:0] on_delay_ff [NUM_OUTPUTS];
  logic [15:0] hold_ff [NUM_OUTPUTS];
  logic pol_ff [NUM_OUTPUTS];
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [15:0] tick_cnt_ff;
  logic tick_ff;
  logic card_s1_ff, card_s2_ff, card_s3_ff, card_ff;
  logic [NUM_OUTPUTS-1:0] pins;

  // Decode of the current APB address.
  logic setup;
  logic [1:0] sel_out;
  logic [3:0] sel_reg;
  logic in_out_area;
  logic is_status;
  logic card_blocked;
  logic mapped;
  logic [4:0] wr_assign;
  logic [15:0] wr_value;
  logic wr_bad;
  logic [4:0] cur_assign;
  assign setup = psel && !penable;
  assign sel_out = paddr[5:4];
  assign sel_reg = paddr[3:0];
  assign in_out_area = paddr[11:6] == 6'h00;
  assign is_status = paddr == REG_STATUS;
  assign card_blocked = sel_out[1] && !card_ff;
  assign mapped = (in_out_area && !card_blocked) || is_status;
  assign wr_assign = pwdata[4:0];
  assign wr_value = pwdata[15:0];
  assign cur_assign = assign_ff[sel_out];
  // A write that breaks a range or a pinned setting is refused with an error.
  logic bad_assign;
  logic bad_on_delay;
  logic bad_hold;
  logic bad_polarity;
  logic bad_align;
  // A code past the source list shows up as set bits above the five-bit field.
  assign bad_assign = (sel_reg == REG_ASSIGN) && (pwdata[31:5] != 27'h0000000);
  assign bad_on_delay = (sel_reg == REG_ON_DELAY) && (fixed_on_delay(cur_assign)
    ? wr_value != 16'h0000 : wr_value > ON_DELAY_MAX_MS);
  assign bad_hold = (sel_reg == REG_HOLD) && (fixed_hold(cur_assign)
    ? wr_value != 16'h0000 : wr_value > HOLD_MAX_MS);
  assign bad_polarity = (sel_reg == REG_POLARITY) && pwdata[POL_BIT]
    && fixed_polarity(cur_assign);
  // Registers are whole words; a write to a byte offset inside a word is refused, a read there returns zero, with an error only in blocked or status words.
  assign bad_align = sel_reg[1:0] != 2'b00;
  assign wr_bad = bad_assign || bad_on_delay || bad_hold || bad_polarity || bad_align;

  // Read mux. A blocked or unmapped address reads zero with an error, never a stale
  // setting, so software cannot mistake a missing card for a default value.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    if (is_status) begin
      rd_word = {26'h0, card_ff, 1'b0, pins};
    end else begin
      unique case (sel_reg)
        REG_ASSIGN: rd_word = {27'h0, cur_assign};
        REG_ON_DELAY: rd_word = {16'h0, on_delay_ff[sel_out]};
        REG_HOLD: rd_word = {16'h0, hold_ff[sel_out]};
        REG_POLARITY: rd_word = {31'h0, pol_ff[sel_out]};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // Pready rises in the access phase itself, so no wait state is ever inserted.
  // Error and read data are decided from the setup cycle and stand for one cycle.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && (!mapped || (pwrite && !is_status && wr_bad));
      prdata_ff <= (setup && !pwrite && mapped) ? rd_word : 32'h00000000;
    end
  end

  // Writes land at the access edge, where the master sees pready high; the checks
  // see the same held address and data there as they did in the setup cycle.
  logic access;
  logic do_write;
  assign access = psel && penable && pready_ff;
  assign do_write = access && pwrite && in_out_area && !card_blocked && !wr_bad;

  // Settings; a new pinned assignment also forces its pinned values.
  // A refused write leaves every setting untouched, so a read back shows what holds.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        assign_ff[i] <= ASSIGN_RESET;
        on_delay_ff[i] <= DELAY_RESET;
        hold_ff[i] <= DELAY_RESET;
        pol_ff[i] <= POL_RESET;
      end
    end else if (do_write) begin
      unique case (sel_reg)
        REG_ASSIGN: begin
          assign_ff[sel_out] <= wr_assign;
          if (fixed_on_delay(wr_assign)) on_delay_ff[sel_out] <= 16'h0000;
          if (fixed_hold(wr_assign)) hold_ff[sel_out] <= 16'h0000;
          if (fixed_polarity(wr_assign)) pol_ff[sel_out] <= 1'b0;
        end
        REG_ON_DELAY: on_delay_ff[sel_out] <= wr_value;
        REG_HOLD: hold_ff[sel_out] <= wr_value;
        REG_POLARITY: pol_ff[sel_out] <= pwdata[POL_BIT];
        default: ;
      endcase
    end
  end

  // Card detect pin is asynchronous: three stages, accept when the last two agree.
  // A glitch shorter than a cycle never reaches the decode, at the cost of latency.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      card_s1_ff <= 1'b0;
      card_s2_ff <= 1'b0;
      card_s3_ff <= 1'b0;
      card_ff <= 1'b0;
    end else begin
      card_s1_ff <= card_fitted_second;
      card_s2_ff <= card_s1_ff;
      card_s3_ff <= card_s2_ff;
      if (card_s2_ff == card_s3_ff) card_ff <= card_s3_ff;
    end
  end

  // Millisecond tick from the system clock.
  // The tick runs free from reset, so a delay of N ms may end up to one tick early.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= tick_cnt_ff == 16'(TICK_CYCLES - 1);
      tick_cnt_ff <= (tick_cnt_ff == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt_ff + 16'h0001;
    end
  end

  // Channels; the none assignment selects no source and stays false.
  // The pins feed the status word as well as the outputs.
  for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_ch
    logic info;
    assign info = (assign_ff[g] != ASSIGN_NONE) && info_sources[assign_ff[g]];
    loc_channel u_ch (
      .clock(clock),
      .resetn(resetn),
      .tick(tick_ff),
      .info(info),
      .on_delay_ms(on_delay_ff[g]),
      .hold_ms(hold_ff[g]),
      .active_low_polarity(pol_ff[g]),
      .pin(pins[g])
    );
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign logic_out_first = pins[0];
  assign logic_out_second = pins[1];
  assign logic_out_third = pins[2];
  assign logic_out_fourth = pins[3];
endmodule // logic_output_conditioner
`default_nettype wire

/* File: test/loc_checker_assertions.sv */
// Port assertions for the logic output conditioner.
`timescale 1ns/100ps
`default_nettype none
module loc_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic card_fitted_second,
  input wire logic logic_out_first
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // A setup cycle, and a setup that writes one per-output setting.
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence set_wr_s;
    setup_s ##0 (pwrite && paddr < 12'h040);
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  reset_clear_a: assert property ($rose(resetn) |-> !logic_out_first)
    else $error("output set after reset");
  // The detect pin must have stayed low long enough to pass all three stages.
  card_gate_a: assert property ((!card_fitted_second) [*6] ##0 (setup_s ##0
    paddr[11:5] == 7'h01) |=> pslverr)
    else $error("absent card reachable");
  assign_range_a: assert property (set_wr_s ##0 (paddr[3:0] == 4'h0
    && pwdata > 32'd31) |=> pslverr) else $error("bad source taken");
  delay_range_a: assert property (set_wr_s ##0 (paddr[3:0] == 4'h4
    && pwdata[15:0] > 16'd60000) |=> pslverr) else $error("long delay taken");
  hold_range_a: assert property (set_wr_s ##0 (paddr[3:0] == 4'h8
    && pwdata[15:0] > 16'd9999) |=> pslverr) else $error("long hold taken");
endmodule // loc_checker
bind logic_output_conditioner loc_checker chk_u (.clock(clock), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .card_fitted_second(card_fitted_second),
  .logic_out_first(logic_out_first));
`default_nettype wire

/* File: test/output_load.sv */
// Model of the external equipment wired to the four logic outputs.
`timescale 1ns/100ps
`default_nettype none
module output_load (
  input wire logic clock,
  input wire logic [3:0] pins,
  output logic [3:0] seen_ff
);
  // The equipment samples on the clock, so a glitch shorter than a cycle is not seen.
  always_ff @(posedge clock) begin
    seen_ff <= pins;
  end
endmodule // output_load
`default_nettype wire

/* File: test/logic_output_conditioner_test.sv */
// Self-checking bench for the logic output conditioner.
`timescale 1ns/100ps
`default_nettype none
module logic_output_conditioner_test;
  import loc_pkg::*;
  logic clock, resetn, psel, penable, pwrite, card_fitted_second, ctl, card_ok, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, info_sources, r;
  logic pready, pslverr;
  logic [3:0] pins, seen;
  int err_count, checked, cyc, m[16];
  logic_output_conditioner dut_u (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .info_sources(info_sources),
    .card_fitted_second(card_fitted_second), .logic_out_first(pins[0]),
    .logic_out_second(pins[1]), .logic_out_third(pins[2]), .logic_out_fourth(pins[3]));
  output_load load_u (.clock(clock), .pins(pins), .seen_ff(seen));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Random sources except bit 9, which the sequence steers; also the hang limit.
  always @(posedge clock) begin
    info_sources <= ($urandom & 32'hFFFFFDFF) | {22'h0, ctl, 9'h0};
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      report_and_stop();
    end
  end
  task report_and_stop();
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  // Expected refusal of a write, from the setting limits and pinned assignments.
  function automatic bit refused(input logic [11:0] a, input int v);
    int g;
    g = m[{a[5:4], 2'b00}];
    // Status is read-only; a write there is ignored without an error.
    if (a == REG_STATUS) return 1'b0;
    if (a > 12'h03C || a[1:0] != 2'b00 || (a[5] && !card_ok)) return 1'b1;
    case (a[3:2])
      2'd0: return v > 31;
      2'd1: return v > 60000 || (v != 0 && g inside {[1:5]});
      2'd2: return v > 9999 || (v != 0 && g inside {1, 3});
      default: return v > 1 || (v == 1 && g inside {1, 2, 3, 5});
    endcase
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the bench's cycle limit ends a wait for pready.
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input int v);
    bit bad;
    bad = refused(a, v);
    apb(1'b1, a, v);
    chk(e, bad);
    // Status is read-only, so an accepted write there changes no setting.
    if (!bad && a != REG_STATUS) m[a[5:2]] = v;
    // A pinned assignment clears the settings it pins.
    if (!bad && a != REG_STATUS && a[3:2] == 2'd0) begin
      if (v inside {[1:5]}) m[a[5:2] + 1] = 0;
      if (v inside {1, 3}) m[a[5:2] + 2] = 0;
      if (v inside {1, 2, 3, 5}) m[a[5:2] + 3] = 0;
    end
  endtask
  task rd(input logic [11:0] a);
    bit bad;
    bad = a > 12'h040 || (a[5] && !card_ok);
    apb(1'b0, a, 32'h0);
    chk(e, bad);
    if (!bad) chk(r, m[a[5:2]]);
  endtask
  initial begin
    void'($urandom(20031));
    {resetn, psel, penable, pwrite, card_fitted_second, ctl, card_ok} = 7'h00;
    {paddr, pwdata} = 44'h0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) rd(a[11:0]);
    rd(12'h020);
    wr(12'h024, 5);
    rd(12'h050);
    wr(12'h040, 1);
    card_fitted_second <= 1'b1;
    repeat (8) @(posedge clock);
    card_ok = 1'b1;
    wr(12'h024, 60000);
    wr(12'h028, 10000);
    wr(12'h004, 65535);
    wr(12'h020, 32);
    rd(12'h024);
    for (int c = 1; c < 6; c++) begin
      wr(12'h010, 6);
      wr(12'h014, 7);
      wr(12'h018, 7);
      wr(12'h01C, 1);
      wr(12'h010, c);
      wr(12'h014, 3);
      wr(12'h018, 3);
      wr(12'h01C, 1);
      for (int a = 16; a < 32; a += 4) rd(a[11:0]);
    end
    wr(12'h018, 0);
    wr(12'h010, 0);
    repeat (5) @(posedge clock);
    chk(seen[3:1], 3'b000);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(e, 1'b0);
    chk(r, 32'h00000020);
    wr(12'h000, 9);
    wr(12'h004, 2);
    wr(12'h008, 2);
    ctl <= 1'b1;
    repeat (24000) @(posedge clock);
    chk(seen[0], 1'b0);
    repeat (26100) @(posedge clock);
    chk(seen[0], 1'b1);
    // A one-cycle drop must be cancelled, not turned into a late hold-time change.
    wr(12'h008, 1);
    ctl <= 1'b0;
    @(posedge clock);
    ctl <= 1'b1;
    repeat (25100) @(posedge clock);
    chk(seen[0], 1'b1);
    wr(12'h00C, 1);
    repeat (4) @(posedge clock);
    chk(seen[0], 1'b0);
    wr(12'h008, 0);
    ctl <= 1'b0;
    repeat (4) @(posedge clock);
    chk(seen[0], 1'b1);
    report_and_stop();
  end
endmodule // logic_output_conditioner_test
`default_nettype wire
